//--- pipe_defs.vh
// Purpose: constants for the six-stage pipeline control block
// Assumes: 40 MHz core clock, plain Verilog-2005
// Notes: included by every design file
`ifndef PIPE_DEFS_VH
`define PIPE_DEFS_VH
`define OPC_ALU 4'h0
`define OPC_LOAD 4'h1
`define OPC_STORE 4'h2
`define OPC_JUMP 4'h3
`define OPC_BRANCH 4'h4
`define OPC_MUL 4'h5
`define OPC_DIV 4'h6
`define OPC_MFDIV 4'h7
`define OPC_ATOMIC_BIT_SET_OP 4'h8
`define OPC_ATOMIC_BIT_CLEAR_OP 4'h9
`define OPC_LL 4'hA
`define OPC_SC 4'hB
`define OPC_SYNC 4'hC
`define OPC_WAIT 4'hD
`define OPC_POS 31:28
`define RD_POS 27:23
`define RS_POS 22:18
`define RT_POS 17:13
`define MULW_POS 12
`define UNC_POS 11
`define SIZE_POS 10:9
`define IMM_POS 8:0
`define BOOT_VEC0 32'hBFC00000
`define BOOT_VEC1 32'h9FC00000
`define BOOT_VEC2 32'h80000000
`define BOOT_VEC3 32'hA0000000
`define DIV_MIN_NODSP 6'h0B
`define DIV_MAX_NODSP 6'h22
`define DIV_MIN_DSP 6'h0C
`define DIV_MAX_DSP 6'h26
`define KSEG_MASK 32'h1FFFFFFF
`define USEG_OFS 32'h40000000
`define WBUF_DEPTH 2
`define EXC_NONE 2'h0
`define EXC_ADEL 2'h1
`define EXC_ADES 2'h2
`define EXC_IBE 2'h3
`endif

//--- pipe_divider.v
// Purpose: iterative divide sequencer, non-blocking
// Assumes: one core clock, start is a one-cycle pulse
// Notes: latency set by dividend sign extension
`timescale 1ns/1ps
`include "pipe_defs.vh"
module pipe_divider (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire dsp_i,
    input wire start_i,
    input wire [31:0] dividend_i,
    input wire [4:0] dest_i,
    output reg busy_o,
    output reg [4:0] dest_o
);
    reg [5:0] cnt_q;
    // significant bytes of dividend beyond sign extension
    function [2:0] sig_bytes;
        input [31:0] v;
        begin
            if (v[31:7] == {25{v[31]}})
                sig_bytes = 3'h1;
            else if (v[31:15] == {17{v[31]}})
                sig_bytes = 3'h2;
            else if (v[31:23] == {9{v[31]}})
                sig_bytes = 3'h3;
            else
                sig_bytes = 3'h4;
        end
    endfunction
    wire [5:0] span_nodsp = (`DIV_MAX_NODSP - `DIV_MIN_NODSP) / 6'h3;
    wire [5:0] span_dsp = (`DIV_MAX_DSP - `DIV_MIN_DSP) / 6'h3;
    wire [2:0] nb = sig_bytes(dividend_i) - 3'h1;
    wire [5:0] lat_nodsp = (nb == 3'h3) ? `DIV_MAX_NODSP : `DIV_MIN_NODSP + span_nodsp * {3'h0, nb};
    wire [5:0] lat_dsp = (nb == 3'h3) ? `DIV_MAX_DSP : `DIV_MIN_DSP + span_dsp * {3'h0, nb};
    always @(posedge clk_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
            cnt_q <= 6'h00;
            dest_o <= 5'h00;
        end else if (ce_i) begin
            if (start_i) begin
                busy_o <= 1'b1;
                cnt_q <= (dsp_i ? lat_dsp : lat_nodsp) - 6'h1;
                dest_o <= dest_i;
            end else if (busy_o) begin
                if (cnt_q == 6'h01)
                    busy_o <= 1'b0;
                cnt_q <= cnt_q - 6'h1;
            end
        end
    end
endmodule // pipe_divider

//--- pipe_wbuf.v
// Purpose: write buffer for cacheable stores
// Assumes: drains when the data port is free
// Notes: full stalls the memory stage
`timescale 1ns/1ps
`include "pipe_defs.vh"
module pipe_wbuf (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire push_i,
    input wire [31:0] addr_i,
    input wire [31:0] data_i,
    input wire pop_i,
    output wire empty_o,
    output wire full_o,
    output wire [31:0] addr_o,
    output wire [31:0] data_o
);
    reg [31:0] addr_mem [0:`WBUF_DEPTH-1];
    reg [31:0] data_mem [0:`WBUF_DEPTH-1];
    reg rd_q;
    reg wr_q;
    reg [1:0] cnt_q;
    assign empty_o = (cnt_q == 2'h0);
    assign full_o = (cnt_q == 2'h2);
    assign addr_o = addr_mem[rd_q];
    assign data_o = data_mem[rd_q];
    wire do_push = push_i && !full_o;
    wire do_pop = pop_i && !empty_o;
    always @(posedge clk_i) begin
        if (do_push && ce_i) begin
            addr_mem[wr_q] <= addr_i;
            data_mem[wr_q] <= data_i;
        end
    end
    always @(posedge clk_i) begin
        if (rst_i) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            cnt_q <= 2'h0;
        end else if (ce_i) begin
            if (do_push)
                wr_q <= ~wr_q;
            if (do_pop)
                rd_q <= ~rd_q;
            cnt_q <= cnt_q + {1'b0, do_push} - {1'b0, do_pop};
        end
    end
endmodule // pipe_wbuf

//--- pipe_core.v
// Purpose: six-stage pipeline sequencing and hazard control
// Assumes: single-cycle SRAM ports, one clock, simplified encoding
// Notes: datapath reduced to add; no register file
`timescale 1ns/1ps
`include "pipe_defs.vh"
// Behaviour
// - instructions flow fetch, register, address, execute, memory, write in order
// - results forward to dependent instructions without register file round trip
// - fetch takes instruction word from instruction SRAM port
// - register stage decodes, reads operands, redirects jumps early
// - address stage computes data address, full decode, Booth recode
// - execute evaluates branches and redirects fetch when taken
// - without DSP, 32x32 multiply issues only every other clock
// - with DSP, any multiply issues every clock
// - divide iterates; stall only when its result is consumed early or another divide issues while busy
// - without DSP divide takes 11 to 34 clocks by dividend size
// - with DSP divide takes 12 to 38 clocks by dividend size
// - execute applies fixed mapping address translation
// - memory stage performs load and store data access
// - cacheable stores enter write buffer, drain when port idle
// - uncacheable stores wait until oldest, then write
// - write stage prioritises pending exceptions and flags winner
// - write stage aligns load data to addressed byte lanes
// - atomic set/clear run with interrupts masked throughout
// - drive lock indication for linked load, sync indication for ordering
// - two boot pins select boot vector location
// - wait instruction enters power-down; clock may stop
module pipe_core (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire dsp_i,
    input wire [1:0] boot_sel_i,
    input wire wake_i,
    input wire [31:0] imem_rdata_i,
    input wire [31:0] dmem_rdata_i,
    output reg [31:0] imem_addr_o,
    output reg imem_req_o,
    output reg [31:0] dmem_addr_o,
    output reg [31:0] dmem_wdata_o,
    output reg dmem_req_o,
    output reg dmem_we_o,
    output reg lock_o,
    output reg sync_o,
    output reg int_mask_o,
    output reg sleep_o,
    output reg [1:0] exc_code_o,
    output reg exc_o,
    output reg wb_en_o,
    output reg [4:0] wb_reg_o,
    output reg [31:0] wb_data_o
);
    reg [1:0] boot_m_q;
    reg [1:0] boot_s_q;
    reg wake_m_q;
    reg wake_s_q;
    reg [31:0] pc_q;
    reg boot_q;
    reg r_v_q, a_v_q, e_v_q, m_v_q, w_v_q;
    reg [31:0] r_ir_q, a_ir_q, e_ir_q, m_ir_q, w_ir_q;
    reg [31:0] r_pc_q;
    reg [31:0] a_op_q, e_op_q, e_addr_q, m_res_q, m_addr_q, w_res_q, w_addr_q;
    reg [31:0] a_opb_q, e_opb_q, m_opb_q;
    reg [2:0] e_booth_q;
    reg mul_busy_q;
    reg [1:0] atom_q;
    reg [31:0] atom_data_q;
    reg [1:0] w_exc_q;
    wire div_busy;
    wire [4:0] div_dest;
    wire wb_empty, wb_full;
    wire [31:0] wb_addr, wb_data;
    function [3:0] opc;
        input [31:0] ir;
        opc = ir[`OPC_POS];
    endfunction
    function uses;
        input [31:0] ir;
        input [4:0] r;
        uses = (r != 5'h00) && (ir[`RS_POS] == r || ir[`RT_POS] == r);
    endfunction
    // fixed mapping: kseg0/1 strip top bits, user space offset
    function [31:0] fmt_map;
        input [31:0] va;
        fmt_map = va[31] ? (va & `KSEG_MASK) : (va + `USEG_OFS);
    endfunction
    wire [31:0] boot_vec = (boot_s_q == 2'h0) ? `BOOT_VEC0 : (boot_s_q == 2'h1) ? `BOOT_VEC1 :
        (boot_s_q == 2'h2) ? `BOOT_VEC2 : `BOOT_VEC3;
    wire [3:0] r_op = opc(r_ir_q);
    wire [3:0] a_op = opc(a_ir_q);
    wire [3:0] e_op = opc(e_ir_q);
    wire [3:0] m_op = opc(m_ir_q);
    // load-use: loaded value only exists after memory stage
    wire ld_hz = a_v_q && (a_op == `OPC_LOAD || a_op == `OPC_LL) && uses(r_ir_q, a_ir_q[`RD_POS]);
    wire div_hz = r_v_q && r_op == `OPC_MFDIV && (div_busy || (a_v_q && a_op == `OPC_DIV) || (e_v_q && e_op == `OPC_DIV));
    wire div_hz2 = r_v_q && r_op == `OPC_DIV && div_busy;
    wire mul_hz = a_v_q && a_op == `OPC_MUL && a_ir_q[`MULW_POS] && !dsp_i && mul_busy_q;
    wire older_live = w_v_q;
    wire unc_st = m_v_q && m_op == `OPC_STORE && m_ir_q[`UNC_POS];
    wire m_stall = (unc_st && (older_live || !wb_empty)) ||
        (m_v_q && m_op == `OPC_STORE && !m_ir_q[`UNC_POS] && wb_full) ||
        (m_v_q && (m_op == `OPC_ATOMIC_BIT_SET_OP || m_op == `OPC_ATOMIC_BIT_CLEAR_OP) && atom_q != 2'h2) ||
        (m_v_q && (m_op == `OPC_LOAD || m_op == `OPC_LL) && !wb_empty);
    wire div_start = e_v_q && e_op == `OPC_DIV && !m_stall;
    wire sc_st = m_v_q && m_op == `OPC_SC && lock_o;
    wire a_stall = m_stall || mul_hz;
    wire r_stall = a_stall || ld_hz || div_hz || div_hz2;
    wire e_taken = e_v_q && e_op == `OPC_BRANCH && (e_op_q == e_opb_q);
    wire r_jump = r_v_q && r_op == `OPC_JUMP && !r_stall && !e_taken;
    wire r_wait = r_v_q && r_op == `OPC_WAIT;
    // forwarding from execute, memory and write results
    function [31:0] fwd;
        input [4:0] r;
        input [31:0] ex, mm, wr;
        begin
            if (r == 5'h00)
                fwd = 32'h00000000;
            else if (e_v_q && e_ir_q[`RD_POS] == r)
                fwd = ex;
            else if (m_v_q && m_ir_q[`RD_POS] == r)
                fwd = mm;
            else if (w_v_q && w_ir_q[`RD_POS] == r)
                fwd = wr;
            else
                fwd = 32'h00000000;
        end
    endfunction
    wire [31:0] e_res = e_op_q + e_opb_q;
    wire [31:0] opa = fwd(r_ir_q[`RS_POS], e_res, m_res_q, w_res_q);
    wire [31:0] opb = fwd(r_ir_q[`RT_POS], e_res, m_res_q, w_res_q);
    wire wb_pop = !wb_empty && !(m_v_q && (m_op == `OPC_ATOMIC_BIT_SET_OP || m_op == `OPC_ATOMIC_BIT_CLEAR_OP));
    // load aligner by byte offset and size
    function [31:0] align;
        input [31:0] d;
        input [1:0] off;
        input [1:0] sz;
        reg [31:0] sh;
        begin
            sh = d >> {off, 3'h0};
            case (sz)
                2'h0: align = {24'h000000, sh[7:0]};
                2'h1: align = {16'h0000, sh[15:0]};
                default: align = sh;
            endcase
        end
    endfunction
    always @(posedge clk_i) if (ce_i) begin
        boot_m_q <= boot_sel_i;
        boot_s_q <= boot_m_q;
        wake_m_q <= wake_i;
        wake_s_q <= wake_m_q;
    end
    always @(posedge clk_i) begin
        if (rst_i) begin
            pc_q <= 32'h00000000;
            boot_q <= 1'b1;
            r_v_q <= 1'b0;
            a_v_q <= 1'b0;
            e_v_q <= 1'b0;
            m_v_q <= 1'b0;
            w_v_q <= 1'b0;
            r_ir_q <= 32'h00000000; a_ir_q <= 32'h00000000; e_ir_q <= 32'h00000000;
            m_ir_q <= 32'h00000000; w_ir_q <= 32'h00000000; r_pc_q <= 32'h00000000;
            a_op_q <= 32'h00000000; a_opb_q <= 32'h00000000; e_op_q <= 32'h00000000;
            e_opb_q <= 32'h00000000; e_addr_q <= 32'h00000000; m_res_q <= 32'h00000000;
            m_addr_q <= 32'h00000000; m_opb_q <= 32'h00000000; w_res_q <= 32'h00000000;
            w_addr_q <= 32'h00000000; e_booth_q <= 3'h0; mul_busy_q <= 1'b0;
            atom_q <= 2'h0; atom_data_q <= 32'h00000000; w_exc_q <= `EXC_NONE;
            imem_addr_o <= 32'h00000000; imem_req_o <= 1'b0;
            dmem_addr_o <= 32'h00000000; dmem_wdata_o <= 32'h00000000;
            dmem_req_o <= 1'b0; dmem_we_o <= 1'b0;
            lock_o <= 1'b0; sync_o <= 1'b0; int_mask_o <= 1'b0; sleep_o <= 1'b0;
            exc_code_o <= `EXC_NONE; exc_o <= 1'b0;
            wb_en_o <= 1'b0; wb_reg_o <= 5'h00; wb_data_o <= 32'h00000000;
        end else if (ce_i) begin
            // fetch
            if (boot_q) begin
                pc_q <= boot_vec;
                boot_q <= 1'b0;
                imem_req_o <= 1'b1;
                imem_addr_o <= boot_vec;
            end else if (sleep_o) begin
                if (wake_s_q) begin
                    sleep_o <= 1'b0;
                    imem_req_o <= 1'b1;
                end
            end else if (e_taken) begin
                pc_q <= e_addr_q;
                imem_addr_o <= e_addr_q;
                r_v_q <= 1'b0;
            end else if (r_jump) begin
                pc_q <= r_pc_q + {23'h000000, r_ir_q[`IMM_POS]};
                imem_addr_o <= r_pc_q + {23'h000000, r_ir_q[`IMM_POS]};
                r_v_q <= 1'b0;
            end else if (r_wait && !r_stall) begin
                sleep_o <= 1'b1;
                imem_req_o <= 1'b0;
                r_v_q <= 1'b0;
            end else if (!r_stall && imem_req_o) begin
                r_ir_q <= imem_rdata_i;
                r_pc_q <= pc_q;
                r_v_q <= 1'b1;
                pc_q <= pc_q + 32'h00000004;
                imem_addr_o <= pc_q + 32'h00000004;
            end
            // register to address
            if (!r_stall) begin
                a_v_q <= r_v_q && !e_taken && r_op != `OPC_JUMP && r_op != `OPC_WAIT;
                a_ir_q <= r_ir_q;
                a_op_q <= opa;
                a_opb_q <= opb;
            end else if (!a_stall) begin
                a_v_q <= 1'b0;
            end
            // address to execute
            if (!a_stall) begin
                e_v_q <= a_v_q && !e_taken;
                e_ir_q <= a_ir_q;
                e_op_q <= a_op_q;
                e_opb_q <= a_opb_q;
                e_addr_q <= a_op_q + {23'h000000, a_ir_q[`IMM_POS]};
                e_booth_q <= a_opb_q[2:0];
                mul_busy_q <= a_v_q && a_op == `OPC_MUL && a_ir_q[`MULW_POS] && !dsp_i;
            end else if (!m_stall) begin
                e_v_q <= 1'b0;
                mul_busy_q <= 1'b0;
            end
            // execute to memory
            if (!m_stall) begin
                m_v_q <= e_v_q;
                m_ir_q <= e_ir_q;
                m_res_q <= e_res;
                m_addr_q <= fmt_map(e_addr_q);
                m_opb_q <= e_opb_q;
            end
            // memory access
            dmem_req_o <= 1'b0;
            dmem_we_o <= 1'b0;
            if (m_v_q && (m_op == `OPC_ATOMIC_BIT_SET_OP || m_op == `OPC_ATOMIC_BIT_CLEAR_OP)) begin
                int_mask_o <= 1'b1;
                if (atom_q == 2'h0) begin
                    dmem_req_o <= 1'b1;
                    dmem_addr_o <= m_addr_q;
                    atom_q <= 2'h1;
                end else if (atom_q == 2'h1) begin
                    atom_data_q <= (m_op == `OPC_ATOMIC_BIT_SET_OP) ? (dmem_rdata_i | m_opb_q) : (dmem_rdata_i & ~m_opb_q);
                    dmem_req_o <= 1'b1;
                    dmem_we_o <= 1'b1;
                    dmem_wdata_o <= (m_op == `OPC_ATOMIC_BIT_SET_OP) ? (dmem_rdata_i | m_opb_q) : (dmem_rdata_i & ~m_opb_q);
                    atom_q <= 2'h2;
                end else begin
                    atom_q <= 2'h0;
                end
            end else begin
                int_mask_o <= 1'b0;
                atom_q <= 2'h0;
                if (m_v_q && !m_stall && (m_op == `OPC_LOAD || m_op == `OPC_LL || unc_st || sc_st)) begin
                    dmem_req_o <= 1'b1;
                    dmem_we_o <= unc_st || sc_st;
                    dmem_addr_o <= m_addr_q;
                    dmem_wdata_o <= m_opb_q;
                end else if (wb_pop) begin
                    dmem_req_o <= 1'b1;
                    dmem_we_o <= 1'b1;
                    dmem_addr_o <= wb_addr;
                    dmem_wdata_o <= wb_data;
                end
            end
            if (m_v_q && !m_stall && m_op == `OPC_LL)
                lock_o <= 1'b1;
            else if (m_v_q && !m_stall && m_op == `OPC_SC)
                lock_o <= 1'b0;
            sync_o <= m_v_q && !m_stall && m_op == `OPC_SYNC;
            // write stage
            w_v_q <= m_v_q && !m_stall;
            w_ir_q <= m_ir_q;
            w_res_q <= m_res_q;
            w_addr_q <= m_addr_q;
            if (m_addr_q[1:0] != 2'h0 && m_ir_q[`SIZE_POS] == 2'h2 && m_op == `OPC_LOAD)
                w_exc_q <= `EXC_ADEL;
            else if (m_addr_q[1:0] != 2'h0 && m_ir_q[`SIZE_POS] == 2'h2 && m_op == `OPC_STORE)
                w_exc_q <= `EXC_ADES;
            else if (m_op > `OPC_WAIT)
                w_exc_q <= `EXC_IBE;
            else
                w_exc_q <= `EXC_NONE;
            exc_o <= w_v_q && w_exc_q != `EXC_NONE;
            exc_code_o <= w_v_q ? w_exc_q : `EXC_NONE;
            wb_en_o <= w_v_q && w_exc_q == `EXC_NONE && opc(w_ir_q) != `OPC_STORE;
            wb_reg_o <= w_ir_q[`RD_POS];
            wb_data_o <= (opc(w_ir_q) == `OPC_LOAD || opc(w_ir_q) == `OPC_LL) ?
                align(dmem_rdata_i, w_addr_q[1:0], w_ir_q[`SIZE_POS]) : w_res_q;
        end
    end
    pipe_divider u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .dsp_i(dsp_i),
        .start_i(div_start),
        .dividend_i(e_op_q),
        .dest_i(e_ir_q[`RD_POS]),
        .busy_o(div_busy),
        .dest_o(div_dest)
    );
    pipe_wbuf u_wbuf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .push_i(m_v_q && !m_stall && m_op == `OPC_STORE && !m_ir_q[`UNC_POS]),
        .addr_i(m_addr_q),
        .data_i(m_opb_q),
        .pop_i(wb_pop),
        .empty_o(wb_empty),
        .full_o(wb_full),
        .addr_o(wb_addr),
        .data_o(wb_data)
    );
endmodule // pipe_core

//--- pipe_core_assertions.sv
// Purpose: port-level checks on pipe_core
// Assumes: one clock, sync active-high reset
// Notes: bound to pipe_core below
`timescale 1ns/1ps
`include "pipe_defs.vh"
module pipe_core_assertions (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire [1:0] boot_sel_i,
    input wire wake_i,
    input wire [31:0] imem_addr_o,
    input wire imem_req_o,
    input wire dmem_req_o,
    input wire dmem_we_o,
    input wire lock_o,
    input wire sync_o,
    input wire int_mask_o,
    input wire sleep_o,
    input wire [1:0] exc_code_o,
    input wire exc_o,
    input wire wb_en_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [31:0] vec;
    always_comb vec = boot_sel_i[1] ? (boot_sel_i[0] ? `BOOT_VEC3 : `BOOT_VEC2)
                                    : (boot_sel_i[0] ? `BOOT_VEC1 : `BOOT_VEC0);
    property p_reset_quiet;
        $fell(rst_i) |-> !imem_req_o && !dmem_req_o && !wb_en_o && !sleep_o && !lock_o;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("output active out of reset");
    property p_boot;
        $fell(rst_i) && ce_i |=> imem_req_o && imem_addr_o == vec;
    endproperty
    a_boot: assert property (p_boot) else $error("first fetch not at boot vector");
    property p_freeze;
        !ce_i |=> $stable(imem_addr_o) && $stable(lock_o) && $stable(sleep_o) && $stable(int_mask_o);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");
    property p_sleep_hold;
        sleep_o && !wake_i && !$past(wake_i) && !$past(wake_i, 2) |=> $stable(imem_addr_o);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("fetch moved in power-down");
    property p_wake;
        $rose(wake_i) && sleep_o && ce_i |-> ##[1:6] !sleep_o;
    endproperty
    a_wake: assert property (p_wake) else $error("no exit from power-down");
    property p_sync;
        sync_o |=> !sync_o;
    endproperty
    a_sync: assert property (p_sync) else $error("sync indication too long");
    property p_write_req;
        dmem_we_o |-> dmem_req_o;
    endproperty
    a_write_req: assert property (p_write_req) else $error("write enable without request");
    property p_exc;
        exc_o |-> exc_code_o != `EXC_NONE;
    endproperty
    a_exc: assert property (p_exc) else $error("exception flagged without cause");
    property p_atomic;
        $rose(int_mask_o) |-> ##[0:8] (dmem_req_o && !dmem_we_o && int_mask_o)
            ##[1:8] (dmem_req_o && dmem_we_o && int_mask_o);
    endproperty
    a_atomic: assert property (p_atomic) else $error("atomic access not masked");
    c_atomic: cover property ($rose(int_mask_o));
    c_wake: cover property ($fell(sleep_o));
    c_sync: cover property (sync_o);
    c_exc: cover property (exc_o);
endmodule // pipe_core_assertions
bind pipe_core pipe_core_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .boot_sel_i(boot_sel_i),
    .wake_i(wake_i), .imem_addr_o(imem_addr_o), .imem_req_o(imem_req_o), .dmem_req_o(dmem_req_o),
    .dmem_we_o(dmem_we_o), .lock_o(lock_o), .sync_o(sync_o), .int_mask_o(int_mask_o), .sleep_o(sleep_o),
    .exc_code_o(exc_code_o), .exc_o(exc_o), .wb_en_o(wb_en_o));

//--- sram_model.sv
// Purpose: instruction and data SRAM model
// Assumes: zero wait, read data in the request cycle
// Notes: idle read buses toggle
`timescale 1ns/1ps
module sram_model (
    input wire clk_i,
    input wire [31:0] imem_addr_i,
    input wire imem_req_i,
    output wire [31:0] imem_rdata_o,
    input wire [31:0] dmem_addr_i,
    input wire [31:0] dmem_wdata_i,
    input wire dmem_req_i,
    input wire dmem_we_i,
    output wire [31:0] dmem_rdata_o
);
    logic [31:0] imem [0:63];
    logic [31:0] dmem [0:63];
    logic [31:0] i_last = 32'h00000000;
    logic [31:0] d_last = 32'h00000000;
    assign imem_rdata_o = imem_req_i ? imem[imem_addr_i[7:2]] : ~i_last;
    assign dmem_rdata_o = (dmem_req_i && !dmem_we_i) ? dmem[dmem_addr_i[7:2]] : ~d_last;
    always @(posedge clk_i) begin
        i_last <= imem_rdata_o;
        d_last <= dmem_rdata_o;
        if (dmem_req_i && dmem_we_i) begin
            dmem[dmem_addr_i[7:2]] <= dmem_wdata_i;
        end
    end
endmodule // sram_model

//--- pipe_core_tb.sv
// Purpose: directed bench for pipe_core
// Assumes: sram_model on both ports, checker bound
// Notes: each scenario reloads code and resets
`timescale 1ns/1ps
`include "pipe_defs.vh"
module pipe_core_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic dsp_i = 1'b0;
    logic [1:0] boot_sel_i = 2'h0;
    logic wake_i = 1'b0;
    wire [31:0] imem_rdata_i, dmem_rdata_i, imem_addr_o, dmem_addr_o, dmem_wdata_o, wb_data_o;
    wire [1:0] exc_code_o;
    wire [4:0] wb_reg_o;
    wire imem_req_o, dmem_req_o, dmem_we_o, lock_o, sync_o, int_mask_o, sleep_o, exc_o, wb_en_o;
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;
    int n_sync, n_exc, lock_seen;
    logic [1:0] exc_first;
    logic [4:0] wb_q[$];
    int wb_t[$];
    logic [33:0] dm_q[$];
    always #12.5 clk_i = ~clk_i;
    pipe_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .dsp_i(dsp_i), .boot_sel_i(boot_sel_i),
        .wake_i(wake_i), .imem_rdata_i(imem_rdata_i), .dmem_rdata_i(dmem_rdata_i), .imem_addr_o(imem_addr_o),
        .imem_req_o(imem_req_o), .dmem_addr_o(dmem_addr_o), .dmem_wdata_o(dmem_wdata_o), .dmem_req_o(dmem_req_o),
        .dmem_we_o(dmem_we_o), .lock_o(lock_o), .sync_o(sync_o), .int_mask_o(int_mask_o), .sleep_o(sleep_o),
        .exc_code_o(exc_code_o), .exc_o(exc_o), .wb_en_o(wb_en_o), .wb_reg_o(wb_reg_o), .wb_data_o(wb_data_o));
    sram_model u_mem (.clk_i(clk_i), .imem_addr_i(imem_addr_o), .imem_req_i(imem_req_o),
        .imem_rdata_o(imem_rdata_i), .dmem_addr_i(dmem_addr_o), .dmem_wdata_i(dmem_wdata_o),
        .dmem_req_i(dmem_req_o), .dmem_we_i(dmem_we_o), .dmem_rdata_o(dmem_rdata_i));
    always @(negedge clk_i) begin
        cyc++;
        if (wb_en_o === 1'b1) begin
            wb_q.push_back(wb_reg_o);
            wb_t.push_back(cyc);
        end
        if (dmem_req_o === 1'b1) dm_q.push_back({int_mask_o, dmem_we_o, dmem_addr_o});
        if (sync_o === 1'b1) n_sync++;
        if (lock_o === 1'b1) lock_seen = 1;
        if (exc_o === 1'b1 && n_exc++ == 0) exc_first = exc_code_o;
    end
    function automatic logic [31:0] mk(input logic [3:0] op, input logic [4:0] rd, input logic [4:0] rs,
                                       input logic [1:0] f, input logic [8:0] imm);
        return {op, rd, rs, 5'h00, f, 2'h2, imm};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask
    task automatic check(input bit ok, input string what);
        check_count++;
        if (!ok) begin
            n_errors++;
            $display("MISMATCH at %0t: %s", $time, what);
        end
    endtask
    task automatic conclude;
        $display("checks %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic load(input logic [31:0] p[$]);
        for (int i = 0; i < 64; i++) u_mem.imem[i] = (i < p.size()) ? p[i] : mk(`OPC_WAIT, 0, 0, 0, 0);
    endtask
    task automatic run(input logic [1:0] sel, input logic dsp);
        boot_sel_i = sel;
        dsp_i = dsp;
        rst_i = 1'b1;
        tick(16);
        rst_i = 1'b0;
        wb_q = {};
        wb_t = {};
        dm_q = {};
        n_sync = 0;
        n_exc = 0;
        lock_seen = 0;
        tick(1);
    endtask
    task automatic check_dm(input logic [33:0] e[$]);
        check(dm_q.size() == e.size(), "data access count");
        for (int i = 0; i < e.size() && i < dm_q.size(); i++) check(dm_q[i] === e[i], "data access");
    endtask
    task automatic s_boot;
        logic [31:0] v[4] = '{`BOOT_VEC0, `BOOT_VEC1, `BOOT_VEC2, `BOOT_VEC3};
        for (int s = 0; s < 4; s++) begin
            load('{});
            run(s[1:0], 1'b0);
            check(imem_req_o === 1'b1 && imem_addr_o === v[s], "boot vector");
        end
    endtask
    task automatic s_order;
        int n;
        load('{mk(`OPC_ALU, 1, 0, 0, 1), mk(`OPC_ALU, 2, 1, 0, 1), mk(`OPC_ALU, 3, 2, 0, 1),
               mk(`OPC_ALU, 4, 3, 0, 1)});
        run(2'h0, 1'b0);
        tick(4);
        ce_i = 1'b0;
        tick(5);
        ce_i = 1'b1;
        tick(30);
        check(wb_q.size() == 4, "writeback count");
        for (int i = 0; i < wb_q.size(); i++) check(wb_q[i] === i + 1, "writeback order");
        check(sleep_o === 1'b1, "no power-down");
        wake_i = 1'b1;
        for (n = 0; n < 10 && sleep_o !== 1'b0; n++) tick(1);
        if (n == 10) begin
            n_errors++;
            $display("MISMATCH at %0t: no wake", $time);
            conclude();
        end
        wake_i = 1'b0;
        tick(20);
        check(wb_q.size() == 4, "writeback after wake");
    endtask
    task automatic s_mul;
        logic d[3] = '{1'b0, 1'b0, 1'b1};
        logic [1:0] f[3] = '{2'h2, 2'h0, 2'h2};
        int g[3] = '{2, 1, 1};
        for (int k = 0; k < 3; k++) begin
            load('{mk(`OPC_MUL, 1, 0, f[k], 3), mk(`OPC_MUL, 2, 0, f[k], 3), mk(`OPC_MUL, 3, 0, f[k], 3)});
            run(2'h0, d[k]);
            tick(40);
            check(wb_q.size() == 3, "multiply count");
            for (int i = 1; i < wb_t.size(); i++) check(wb_t[i] - wb_t[i-1] == g[k], "issue rate");
        end
    endtask
    task automatic s_div;
        int p[10] = '{default: -1};
        load('{mk(`OPC_DIV, 7, 0, 0, 0), mk(`OPC_ALU, 8, 0, 0, 1), mk(`OPC_MFDIV, 9, 0, 0, 0)});
        run(2'h0, 1'b0);
        tick(80);
        foreach (wb_q[i]) if (wb_q[i] < 10) p[wb_q[i]] = i;
        check(p[8] >= 0 && p[9] > p[8], "divide blocked later work");
        check(p[7] >= 0 && p[9] >= 0 && wb_t[p[9]] - wb_t[p[7]] >= `DIV_MIN_NODSP, "divide result early");
    endtask
    task automatic s_mem;
        load('{mk(`OPC_STORE, 0, 0, 0, 9'h010), mk(`OPC_STORE, 0, 0, 1, 9'h020), mk(`OPC_LOAD, 5, 0, 0, 9'h010)});
        run(2'h1, 1'b0);
        tick(40);
        check_dm('{{2'b01, 32'h40000010}, {2'b01, 32'h40000020}, {2'b00, 32'h40000010}});
        check(wb_q.size() == 1 && wb_q[0] === 5'd5, "load writeback");
    endtask
    task automatic s_atomic;
        load('{mk(`OPC_ATOMIC_BIT_SET_OP, 0, 0, 0, 9'h030), mk(`OPC_ATOMIC_BIT_CLEAR_OP, 0, 0, 0, 9'h034), mk(`OPC_LL, 6, 0, 0, 9'h040),
               mk(`OPC_SC, 6, 0, 0, 9'h040), mk(`OPC_SYNC, 0, 0, 0, 0)});
        run(2'h0, 1'b0);
        tick(50);
        check_dm('{{2'b10, 32'h40000030}, {2'b11, 32'h40000030}, {2'b10, 32'h40000034}, {2'b11, 32'h40000034},
                   {2'b00, 32'h40000040}, {2'b01, 32'h40000040}});
        check(lock_seen == 1 && lock_o === 1'b0, "lock indication");
        check(n_sync == 1, "sync indication");
    endtask
    task automatic s_exc;
        load('{mk(4'hF, 1, 0, 0, 0)});
        run(2'h0, 1'b0);
        tick(20);
        check(n_exc > 0 && exc_first === `EXC_IBE, "exception code");
    endtask
    initial begin
        s_boot();
        s_order();
        s_mul();
        s_div();
        s_mem();
        s_atomic();
        s_exc();
        conclude();
    end
endmodule // pipe_core_tb
